// file: hw/duog_guard.v
// Purpose: Undervoltage torque limiting and motor overload timing guard
// Assumes: Motor current and torque in raw units; 10 MHz clock
// Notes:   Restart-effective settings latch on reset release or restart
// Operation
// RL1: Selector 0 disables undervoltage, 1 flags host only, 2 limits torque in the drive.
// RL2: In choice 2 the drive limits torque itself; selector changes apply after restart.
// RL3: Sag torque limit spans 0 to 100 percent, default 50, effective at once.
// RL4: Each sag step is one percent of rated torque when clamping the reference.
// RL5: Release time spans 0 to 1000 ms, default 100, effective at once.
// RL6: Power-cut hold time spans 20 to 1000 ms, default 20, effective at once.
// RL7: Software sets the hold time to 1000 ms when using sag ride-through.
// RL8: Overload warning fires at the warning percentage of the alarm time.
// RL9: The warning output is driven when the overload warning is detected.
// RL10: High-load alarm level and curve are fixed and unaffected by settings.
// RL11: Overload accumulates above base current times derating, applied after restart.
// RL12: Derating also shifts the warning time since warning is a fraction of alarm.
// RL13: In choice 2 the limit applies on undervoltage and releases over the release time.
// RL14: In choice 1 the host limits torque during the warning and removes it after.
// RL15: Power cuts shorter than hold keep motor powered, longer drop power and ready.
// RL16: Release rises linearly, hitting the normal limit exactly at the release time.
`include "duog_regs.vh"
`timescale 1ns/1ns
`default_nettype none
module duog_guard #(
  parameter CW       = 16,         // Current and torque width
  parameter OL_LIMIT = 32'd600000, // Low-load overload alarm level
  parameter HI_LIMIT = 16'd50000   // Fixed high-load instantaneous level
) (
  input  wire          mclk,        // 10 MHz control clock
  input  wire          rst_b,       // Async reset, active low
  input  wire [3:0]    addr,        // Register index
  input  wire [15:0]   wdata,       // Write data
  input  wire          wr,          // Write strobe
  input  wire          rd,          // Read strobe
  output reg  [15:0]   rdata_q,     // Read data, one cycle after rd
  input  wire          restart,     // Drive restart, latches setup values
  input  wire          uv_det,      // Main circuit undervoltage pin
  input  wire          mains_ok,    // Main power present pin
  input  wire [CW-1:0] motor_cur,   // Measured motor current
  input  wire [CW-1:0] base_cur,    // Motor base current
  input  wire [CW-1:0] rated_trq,   // Rated torque
  input  wire [CW-1:0] trq_ref,     // Torque reference in
  output reg  [CW-1:0] trq_out_q,   // Clamped torque reference
  output reg           uv_warn_q,   // Undervoltage warning to host
  output reg           warn_q,      // Warning output signal
  output reg           ol_alarm_q,  // Low-load overload alarm
  output reg           hl_alarm_q,  // High-load overload alarm
  output reg           motor_pwr_q, // Motor power enable
  output reg           srdy_q,      // Servo ready
  output reg           irq_q        // Interrupt, level
);
  //////////////////////////////////////////////////////////////////////
  // Reset synchroniser
  reg rs1_q, rs2_q;
  wire rst_n = rs2_q;
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rs1_q <= 1'b0;
      rs2_q <= 1'b0;
    end else begin
      rs1_q <= 1'b1;
      rs2_q <= rs1_q;
    end
  end

  // Pin synchronisers, accepted once stages two and three agree
  reg [2:0] uv_s_q, mo_s_q;
  reg       uv_q, mo_q;
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      uv_s_q <= 3'b000;
      mo_s_q <= 3'b111;
      uv_q   <= 1'b0;
      mo_q   <= 1'b1;
    end else begin
      uv_s_q <= {uv_s_q[1:0], uv_det};
      mo_s_q <= {mo_s_q[1:0], mains_ok};
      if (uv_s_q[1] == uv_s_q[2])
        uv_q <= uv_s_q[2];
      if (mo_s_q[1] == mo_s_q[2])
        mo_q <= mo_s_q[2];
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Millisecond time base
  localparam integer TICK_LAST = `DUOG_TICK_CYC - 1;
  reg [13:0] div_q;
  reg        tick_q;
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      div_q  <= 14'd0;
      tick_q <= 1'b0;
    end else begin
      tick_q <= (div_q == TICK_LAST[13:0]);
      div_q  <= (div_q == TICK_LAST[13:0]) ? 14'd0 : div_q + 14'd1;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Settings; out-of-range percentage and time writes clamp to the nearest bound; the selector clamps its low two bits
  function [9:0] clamp10(input [15:0] v, input [9:0] lo, input [9:0] hi);
    clamp10 = (v < {6'd0, lo}) ? lo : (v > {6'd0, hi}) ? hi : v[9:0];
  endfunction

  reg [1:0] uv_sel_q, uv_run_q;
  reg [6:0] sag_q, warnp_q, der_q, der_run_q;
  reg [9:0] rel_q, hold_q;
  reg [3:0] stat_q, mask_q;
  reg       restart_d1_q;
  wire      latch_setup = !restart_d1_q || restart;
  // Clamped write values, cut to the 7-bit percentage fields
  wire [9:0] sag_cl  = clamp10(wdata, 10'd0, {3'd0, `DUOG_SAG_MAX});
  wire [9:0] warn_cl = clamp10(wdata, {3'd0, `DUOG_WARN_MIN}, {3'd0, `DUOG_WARN_MAX});
  wire [9:0] der_cl  = clamp10(wdata, {3'd0, `DUOG_DER_MIN}, {3'd0, `DUOG_DER_MAX});

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      uv_sel_q     <= `DUOG_UV_OFF;
      sag_q        <= `DUOG_SAG_RST;
      rel_q        <= `DUOG_REL_RST;
      hold_q       <= `DUOG_HOLD_RST;
      warnp_q      <= `DUOG_WARN_RST;
      der_q        <= `DUOG_DER_RST;
      mask_q       <= 4'h0;
      uv_run_q     <= `DUOG_UV_OFF;
      der_run_q    <= `DUOG_DER_RST;
      restart_d1_q <= 1'b0;
    end else begin
      restart_d1_q <= 1'b1;
      // Restart-effective copies, so a live edit cannot jolt a running axis
      if (latch_setup) begin
        uv_run_q  <= uv_sel_q;                                        // [RL2]
        der_run_q <= der_q;                                           // [RL11]
      end
      if (wr) begin
        case (addr)
          `DUOG_OFS_CFG:
            uv_sel_q <= (wdata[1:0] > `DUOG_UV_DRIVE) ? `DUOG_UV_DRIVE : wdata[1:0]; // [RL1]
          `DUOG_OFS_SAG:
            sag_q <= sag_cl[6:0];                                    // [RL3]
          `DUOG_OFS_REL:
            rel_q <= clamp10(wdata, 10'd0, `DUOG_REL_MAX);           // [RL5]
          `DUOG_OFS_HOLD:
            hold_q <= clamp10(wdata, `DUOG_HOLD_MIN, `DUOG_HOLD_MAX); // [RL6]
          `DUOG_OFS_WARN:
            warnp_q <= warn_cl[6:0];                                 // [RL8]
          `DUOG_OFS_DERATE:
            der_q <= der_cl[6:0];                                    // [RL11]
          `DUOG_OFS_MASK:
            mask_q <= wdata[3:0];
          default: ;
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Undervoltage warning and internal limit
  wire uv_en    = (uv_run_q != `DUOG_UV_OFF);                         // [RL1]
  wire uv_act   = uv_en && uv_q;
  wire drv_lim  = (uv_run_q == `DUOG_UV_DRIVE);                       // [RL2]
  reg  uv_act_d_q;
  // Percent of rated torque, one step per percent
  wire [CW+6:0] sag_prod = rated_trq * sag_q;                         // [RL4]
  wire [CW+6:0] sag_div  = sag_prod / `DUOG_FULL_PCT;                 // [RL4]
  wire [CW-1:0] sag_trq  = sag_div[CW-1:0];                           // [RL4]
  wire [CW-1:0] ramp_lim;
  wire          ramp_busy;

  duog_ramp #(.W(CW)) u_ramp (
    .clk    (mclk),
    .rst_n  (rst_n),
    .tick   (tick_q),
    .hold   (drv_lim && uv_act),                                      // [RL13]
    .start  (drv_lim && uv_act_d_q && !uv_act),                       // [RL13]
    .lo     (sag_trq),
    .hi     (rated_trq),
    .dur    (rel_q),
    .lim_q  (ramp_lim),
    .busy_q (ramp_busy)
  );

  // Clamp only while held or releasing; host choice leaves reference alone
  wire lim_on = drv_lim && (uv_act || uv_act_d_q || ramp_busy);
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      uv_act_d_q <= 1'b0;
      uv_warn_q  <= 1'b0;
      trq_out_q  <= {CW{1'b0}};
    end else begin
      uv_act_d_q <= uv_act;
      uv_warn_q  <= uv_act;                                           // [RL1]
      trq_out_q  <= (lim_on && trq_ref > ramp_lim) ? ramp_lim : trq_ref; // [RL13]
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Power-cut hold timing
  reg [9:0] cut_ms_q;
  reg       cut_trip_q;
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cut_ms_q    <= 10'd0;
      cut_trip_q  <= 1'b0;
      motor_pwr_q <= 1'b0;
      srdy_q      <= 1'b0;
    end else begin
      if (mo_q) begin
        cut_ms_q   <= 10'd0;
        cut_trip_q <= 1'b0;
      end else if (tick_q && !cut_trip_q) begin
        cut_ms_q   <= cut_ms_q + 10'd1;
        cut_trip_q <= (cut_ms_q + 10'd1 >= hold_q);                   // [RL15]
      end
      motor_pwr_q <= !cut_trip_q;                                     // [RL15]
      srdy_q      <= !cut_trip_q && mo_q;                             // [RL15]
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Overload accumulator; excess above derated base integrates per ms
  wire [CW+6:0] der_prod = base_cur * der_run_q;
  wire [CW+6:0] der_div  = der_prod / `DUOG_FULL_PCT;
  wire [CW-1:0] der_base = der_div[CW-1:0];                           // [RL11]
  wire [38:0]   warn_prod = {7'd0, OL_LIMIT} * warnp_q;
  wire [38:0]   warn_div  = warn_prod / `DUOG_FULL_PCT;
  wire [31:0]   warn_lvl  = warn_div[31:0];                           // [RL8]
  reg  [31:0]   acc_q;
  wire [CW-1:0] excess = motor_cur - der_base;
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      acc_q      <= 32'd0;
      warn_q     <= 1'b0;
      ol_alarm_q <= 1'b0;
      hl_alarm_q <= 1'b0;
    end else begin
      if (tick_q) begin
        if (motor_cur > der_base)                                     // [RL11]
          acc_q <= (acc_q >= OL_LIMIT) ? acc_q : acc_q + {{(32-CW){1'b0}}, excess};
        else if (acc_q != 32'd0)
          acc_q <= acc_q - 32'd1;
      end
      // Same accumulator feeds both, so derating moves the warning too
      warn_q <= (acc_q >= warn_lvl);                                  // [RL9] [RL12]
      if (acc_q >= OL_LIMIT)
        ol_alarm_q <= 1'b1;
      if (motor_cur >= HI_LIMIT)                                      // [RL10]
        hl_alarm_q <= 1'b1;
      // Restart also empties the thermal sum, else the alarm would return at once
      if (restart) begin
        acc_q      <= 32'd0;
        ol_alarm_q <= 1'b0;
        hl_alarm_q <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Interrupt status: set wins over write-one-to-clear
  wire [3:0] ev;
  assign ev[`DUOG_EV_UVW]  = uv_act && !uv_act_d_q;
  assign ev[`DUOG_EV_OLW]  = (acc_q >= warn_lvl) && !warn_q;
  assign ev[`DUOG_EV_OLA]  = (acc_q >= OL_LIMIT) && !ol_alarm_q;
  assign ev[`DUOG_EV_PCUT] = cut_trip_q && motor_pwr_q;
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      stat_q <= 4'h0;
      irq_q  <= 1'b0;
    end else begin
      stat_q <= (stat_q & ~((wr && addr == `DUOG_OFS_IRQ) ? wdata[3:0] : 4'h0)) | ev;
      irq_q  <= |(stat_q & mask_q);
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Read port, unmapped reads return zero
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= 16'h0000;
    end else if (rd) begin
      case (addr)
        `DUOG_OFS_CFG:    rdata_q <= {14'd0, uv_sel_q};
        `DUOG_OFS_SAG:    rdata_q <= {9'd0, sag_q};
        `DUOG_OFS_REL:    rdata_q <= {6'd0, rel_q};
        `DUOG_OFS_HOLD:   rdata_q <= {6'd0, hold_q};
        `DUOG_OFS_WARN:   rdata_q <= {9'd0, warnp_q};
        `DUOG_OFS_DERATE: rdata_q <= {9'd0, der_q};
        `DUOG_OFS_STAT:   rdata_q <= {9'd0, ramp_busy, srdy_q, motor_pwr_q,
                                      hl_alarm_q, ol_alarm_q, warn_q, uv_warn_q};
        `DUOG_OFS_IRQ:    rdata_q <= {12'd0, stat_q};
        `DUOG_OFS_MASK:   rdata_q <= {12'd0, mask_q};
        `DUOG_OFS_LIMIT:  rdata_q <= ramp_lim;
        `DUOG_OFS_OLACC:  rdata_q <= acc_q[31:16];
        default:          rdata_q <= 16'h0000;
      endcase
    end else begin
      rdata_q <= 16'h0000;
    end
  end
endmodule // duog_guard
`default_nettype wire

// file: hw/duog_regs.vh
// Purpose: Offsets, fields, reset values and timing counts of the drive guard
// Assumes: 10 MHz control clock, 1 ms time base
// Notes:   Definitions only
`ifndef DUOG_REGS_VH
`define DUOG_REGS_VH

// Register offsets (word index on the plain port)
`define DUOG_OFS_CFG      4'h0
`define DUOG_OFS_SAG      4'h1
`define DUOG_OFS_REL      4'h2
`define DUOG_OFS_HOLD     4'h3
`define DUOG_OFS_WARN     4'h4
`define DUOG_OFS_DERATE   4'h5
`define DUOG_OFS_STAT     4'h6
`define DUOG_OFS_IRQ      4'h7
`define DUOG_OFS_MASK     4'h8
`define DUOG_OFS_LIMIT    4'h9
`define DUOG_OFS_OLACC    4'hA

// Undervoltage selector codes
`define DUOG_UV_OFF       2'h0
`define DUOG_UV_HOST      2'h1
`define DUOG_UV_DRIVE     2'h2

// Reset values and ranges
`define DUOG_SAG_RST      7'd50
`define DUOG_SAG_MAX      7'd100
`define DUOG_REL_RST      10'd100
`define DUOG_REL_MAX      10'd1000
`define DUOG_HOLD_RST     10'd20
`define DUOG_HOLD_MIN     10'd20
`define DUOG_HOLD_MAX     10'd1000
`define DUOG_WARN_RST     7'd20
`define DUOG_WARN_MIN     7'd1
`define DUOG_WARN_MAX     7'd100
`define DUOG_DER_RST      7'd100
`define DUOG_DER_MIN      7'd10
`define DUOG_DER_MAX      7'd100
`define DUOG_FULL_PCT     7'd100

// Event bit positions in the interrupt status and mask registers
`define DUOG_EV_UVW       0
`define DUOG_EV_OLW       1
`define DUOG_EV_OLA       2
`define DUOG_EV_PCUT      3

// Time base
`define DUOG_CLK_HZ       10000000
`define DUOG_TICK_MS      1
`define DUOG_TICK_CYC     ((`DUOG_CLK_HZ / 1000) * `DUOG_TICK_MS)

`endif

// file: hw/duog_ramp.v
// Purpose: Linear torque-limit release ramp from sag limit to normal limit
// Assumes: One step per millisecond tick
// Notes:   Error accumulator with a divide by dur spreads the rise over the time
`timescale 1ns/1ns
`default_nettype none
module duog_ramp #(
  parameter W = 16
) (
  input  wire         clk,       // Control clock
  input  wire         rst_n,     // Synchronised reset, active low
  input  wire         tick,      // 1 ms enable pulse
  input  wire         hold,      // Hold at sag limit
  input  wire         start,     // Begin release
  input  wire [W-1:0] lo,        // Sag limit
  input  wire [W-1:0] hi,        // Normal limit
  input  wire [9:0]   dur,       // Release time in ms
  output reg  [W-1:0] lim_q,     // Current limit
  output reg          busy_q     // Release in progress
);
  reg [9:0]   left_q;
  reg [W+9:0] acc_q;
  wire [W-1:0] span = hi - lo;
  wire [W+9:0] sum  = acc_q + {10'd0, span};
  wire [W+9:0] quo  = sum / {{W{1'b0}}, dur};
  wire [W-1:0] inc  = quo[W-1:0];
  //////////////////////////////////////////////////////////////////////
  // Ramp: value is lo + span*elapsed/dur, exact at the final tick
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lim_q  <= {W{1'b1}};
      busy_q <= 1'b0;
      left_q <= 10'd0;
      acc_q  <= {(W+10){1'b0}};
    end else if (hold) begin
      lim_q  <= lo;
      busy_q <= 1'b0;
    end else if (start) begin
      busy_q <= (dur != 10'd0);                        // [RL16]
      lim_q  <= (dur == 10'd0) ? hi : lo;              // [RL16]
      left_q <= dur;
      acc_q  <= {(W+10){1'b0}};
    end else if (busy_q && tick) begin
      if (left_q <= 10'd1) begin
        lim_q  <= hi;                                  // [RL16]
        busy_q <= 1'b0;
      end else begin
        lim_q  <= lim_q + inc;                         // [RL16]
        acc_q  <= sum - ({10'd0, inc} * {{W{1'b0}}, dur});
        left_q <= left_q - 10'd1;
      end
    end else if (!busy_q) begin
      lim_q <= hi;
    end
  end
endmodule // duog_ramp
`default_nettype wire

// file: verif/duog_guard_checker.sv
// Purpose: Port-level checks on the drive guard
// Assumes: One mclk domain, rst_b active low
// Notes:   Bound to duog_guard below
`include "duog_regs.vh"
`timescale 1ns/1ns
`default_nettype none
module duog_guard_checker (
  input wire        mclk,        // Control clock
  input wire        rst_b,       // Reset, active low
  input wire [3:0]  addr,        // Register index
  input wire [15:0] wdata,       // Write data
  input wire        wr,          // Write strobe
  input wire        rd,          // Read strobe
  input wire [15:0] rdata_q,     // Read data
  input wire        restart,     // Restart pulse
  input wire        uv_det,      // Undervoltage pin
  input wire        uv_warn_q,   // Undervoltage warning
  input wire        warn_q,      // Overload warning
  input wire        ol_alarm_q,  // Low-load alarm
  input wire        hl_alarm_q,  // High-load alarm
  input wire        motor_pwr_q, // Motor power
  input wire        srdy_q       // Servo ready
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  //////////////////////////////////////////////////////////////////////////////
  // Register read-back, clamping to range bounds
  property p_rd_idle; !$past(rd) |-> rdata_q == 16'h0000; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
  sequence s_sag_ok;
    wr && addr == `DUOG_OFS_SAG && wdata <= 16'h0064 ##1 rd && addr == `DUOG_OFS_SAG;
  endsequence
  property p_sag_rb; s_sag_ok |=> rdata_q == $past(wdata, 2); endproperty
  a_sag_rb: assert property (p_sag_rb) else $error("sag read-back");
  property p_sag_clamp;
    wr && addr == `DUOG_OFS_SAG && wdata > 16'h0064 ##1 rd && addr == `DUOG_OFS_SAG
      |=> rdata_q == 16'h0064;
  endproperty
  a_sag_clamp: assert property (p_sag_clamp) else $error("sag clamp");
  property p_rel_rb;
    wr && addr == `DUOG_OFS_REL && wdata <= 16'h03E8 ##1 rd && addr == `DUOG_OFS_REL
      |=> rdata_q == $past(wdata, 2);
  endproperty
  a_rel_rb: assert property (p_rel_rb) else $error("release read-back");
  property p_hold_clamp;
    wr && addr == `DUOG_OFS_HOLD && wdata < 16'h0014 ##1 rd && addr == `DUOG_OFS_HOLD
      |=> rdata_q == 16'h0014;
  endproperty
  a_hold_clamp: assert property (p_hold_clamp) else $error("hold clamp");
  //////////////////////////////////////////////////////////////////////////////
  // Alarms stay until a restart; restart effect may lag two cycles
  property p_ol_sticky;
    ol_alarm_q && !restart && !$past(restart) && !$past(restart, 2) |=> ol_alarm_q;
  endproperty
  a_ol_sticky: assert property (p_ol_sticky) else $error("ol alarm dropped");
  property p_hl_sticky;
    hl_alarm_q && !restart && !$past(restart) && !$past(restart, 2) |=> hl_alarm_q;
  endproperty
  a_hl_sticky: assert property (p_hl_sticky) else $error("hl alarm dropped");
  property p_srdy_pwr; srdy_q |-> motor_pwr_q; endproperty
  a_srdy_pwr: assert property (p_srdy_pwr) else $error("ready without power");
  // Pin is synchronised, so its cause lies a few cycles back
  property p_uv_cause; $rose(uv_warn_q) |-> $past(uv_det, 3); endproperty
  a_uv_cause: assert property (p_uv_cause) else $error("uv warn uncaused");
  property p_warn_first; $rose(ol_alarm_q) |-> warn_q; endproperty
  a_warn_first: assert property (p_warn_first) else $error("alarm before warn");
  c_sag_rb: cover property (s_sag_ok);
  c_uv: cover property ($rose(uv_warn_q));
  c_ol: cover property ($rose(ol_alarm_q));
endmodule // duog_guard_checker
bind duog_guard duog_guard_checker chk_u (.mclk(mclk), .rst_b(rst_b), .addr(addr),
  .wdata(wdata), .wr(wr), .rd(rd), .rdata_q(rdata_q), .restart(restart), .uv_det(uv_det),
  .uv_warn_q(uv_warn_q), .warn_q(warn_q), .ol_alarm_q(ol_alarm_q),
  .hl_alarm_q(hl_alarm_q), .motor_pwr_q(motor_pwr_q), .srdy_q(srdy_q));
`default_nettype wire

// file: verif/duog_host_model.sv
// Purpose: Host controller that limits its torque reference while warned
// Assumes: Same clock as the drive
// Notes:   Registered, so the limit lands one cycle after the warning
`timescale 1ns/1ns
`default_nettype none
module duog_host_model (
  input  wire         mclk,             // Control clock
  input  wire         uv_warn,          // Undervoltage warning from drive
  input  wire  [15:0] demand,           // Wanted torque
  input  wire  [15:0] lim,              // Host limit during sag
  output var logic [15:0] trq_ref = 16'h0 // Reference to drive
);
  // Limit only while warned; removed as soon as the warning clears
  always @(posedge mclk) begin
    trq_ref <= (uv_warn && demand > lim) ? lim : demand;
  end
endmodule // duog_host_model
`default_nettype wire

// file: verif/duog_guard_tb.sv
// Purpose: Self-checking bench for the drive guard
// Assumes: 10 MHz mclk, OL_LIMIT shortened to 200
// Notes:   Ramp checks use windows since tick phase is not visible
`include "duog_regs.vh"
`timescale 1ns/1ns
`default_nettype none
module duog_guard_tb;
  logic        mclk = 1'b0;
  logic        rst_b = 1'b0;
  logic [3:0]  addr = 4'h0;
  logic [15:0] wdata = 16'h0;
  logic        wr = 1'b0, rd = 1'b0, restart = 1'b0, uv_det = 1'b0, mains_ok = 1'b1;
  logic [15:0] motor_cur = 16'd600, base_cur = 16'd1000, rated_trq = 16'd1000;
  logic [15:0] demand = 16'd900, host_lim = 16'd400;
  wire  [15:0] rdata_q, trq_ref, trq_out_q;
  wire         uv_warn_q, warn_q, ol_alarm_q, hl_alarm_q, motor_pwr_q, srdy_q, irq_q;
  integer      miscompares = 0, check_count = 0, i;
  logic [3:0]  ta [12] = '{1, 1, 2, 2, 3, 3, 4, 4, 5, 5, 0, 0};
  logic [15:0] td [12] = '{101, 30, 1001, 3, 5, 1000, 0, 20, 5, 100, 3, 0};
  logic [15:0] te [12] = '{100, 30, 1000, 3, 20, 1000, 1, 20, 10, 100, 2, 0};
  logic [15:0] tr [6] = '{0, 50, 100, 20, 20, 100};
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    forever #50 mclk = ~mclk;
  end
  duog_guard #(.OL_LIMIT(32'd200)) dut_u (.mclk(mclk), .rst_b(rst_b), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata_q(rdata_q), .restart(restart),
    .uv_det(uv_det), .mains_ok(mains_ok), .motor_cur(motor_cur), .base_cur(base_cur),
    .rated_trq(rated_trq), .trq_ref(trq_ref), .trq_out_q(trq_out_q),
    .uv_warn_q(uv_warn_q), .warn_q(warn_q), .ol_alarm_q(ol_alarm_q),
    .hl_alarm_q(hl_alarm_q), .motor_pwr_q(motor_pwr_q), .srdy_q(srdy_q), .irq_q(irq_q));
  duog_host_model host_u (.mclk(mclk), .uv_warn(uv_warn_q), .demand(demand),
    .lim(host_lim), .trq_ref(trq_ref));
  //////////////////////////////////////////////////////////////////////////////
  // Shared bus and compare tasks
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %0d expected %0d", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic settle(input int n);
    cyc(n);
    @(negedge mclk);
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge mclk);
    wr <= 1'b0;
  endtask
  // Starts in the time step of an edge, so it may follow a write with no gap
  task automatic rd_now(input logic [3:0] a, input logic [15:0] exp);
    rd <= 1'b1;
    addr <= a;
    @(posedge mclk);
    rd <= 1'b0;
    @(negedge mclk);
    chk(rdata_q, exp);
  endtask
  task automatic kick;
    @(posedge mclk);
    restart <= 1'b1;
    @(posedge mclk);
    restart <= 1'b0;
    cyc(5);
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  // Watchdog at 95000 cycles, well past the roughly 60000 the tests need
  initial begin
    #9_500_000;
    miscompares++;
    wrap_up();
  end
  // Main sequence
  initial begin
    cyc(3);
    rst_b <= 1'b1;
    cyc(3);
    for (i = 0; i < 6; i++) begin
      @(posedge mclk);
      rd_now(i[3:0], tr[i]);
    end
    for (i = 0; i < 12; i++) begin
      wr_reg(ta[i], td[i]);
      rd_now(ta[i], te[i]);
    end
    @(posedge mclk);
    rd_now(4'hF, 16'h0);
    cyc(1);
    // Short mains dip is ridden through
    mains_ok <= 1'b0;
    cyc(50);
    mains_ok <= 1'b1;
    settle(10);
    chk(srdy_q, 1'b1);
    chk(motor_pwr_q, 1'b1);
    // Selector written but not yet restarted: still off
    wr_reg(`DUOG_OFS_MASK, 16'h0001);
    wr_reg(`DUOG_OFS_CFG, 16'h0001);
    uv_det <= 1'b1;
    settle(20);
    chk(uv_warn_q, 1'b0);
    chk(irq_q, 1'b0);
    cyc(1);
    uv_det <= 1'b0;
    cyc(10);
    kick();
    uv_det <= 1'b1;
    settle(20);
    chk(uv_warn_q, 1'b1);
    chk(trq_out_q, 16'd400);
    chk(irq_q, 1'b1);
    wr_reg(`DUOG_OFS_IRQ, 16'h0001);
    settle(5);
    chk(irq_q, 1'b0);
    cyc(1);
    uv_det <= 1'b0;
    settle(20);
    chk(trq_out_q, 16'd900);
    // Drive-internal limiting with a 3 ms release
    host_lim <= 16'hFFFF;
    wr_reg(`DUOG_OFS_CFG, 16'h0002);
    kick();
    uv_det <= 1'b1;
    settle(20);
    chk(trq_out_q, 16'd300);
    wr_reg(`DUOG_OFS_SAG, 16'd40);
    settle(5);
    chk(trq_out_q, 16'd400);
    cyc(1);
    uv_det <= 1'b0;
    settle(11000);
    chk(trq_out_q > 16'd400 && trq_out_q < 16'd900, 1'b1);
    settle(20000);
    chk(trq_out_q, 16'd900);
    wr_reg(`DUOG_OFS_REL, 16'd0);
    uv_det <= 1'b1;
    cyc(20);
    uv_det <= 1'b0;
    settle(20);
    chk(trq_out_q, 16'd900);
    // Derating waits for restart, then warning precedes alarm
    wr_reg(`DUOG_OFS_DERATE, 16'd50);
    settle(12000);
    chk(warn_q, 1'b0);
    kick();
    for (i = 0; i < 12000 && warn_q !== 1'b1; i++) @(posedge mclk);
    @(negedge mclk);
    chk(warn_q, 1'b1);
    chk(ol_alarm_q, 1'b0);
    for (i = 0; i < 25000 && ol_alarm_q !== 1'b1; i++) @(posedge mclk);
    @(negedge mclk);
    chk(ol_alarm_q, 1'b1);
    chk(hl_alarm_q, 1'b0);
    kick();
    @(negedge mclk);
    chk(ol_alarm_q, 1'b0);
    // High-load level is fixed whatever the derating
    cyc(1);
    motor_cur <= 16'd40000;
    settle(20);
    chk(hl_alarm_q, 1'b0);
    cyc(1);
    motor_cur <= 16'd60000;
    settle(20);
    chk(hl_alarm_q, 1'b1);
    wrap_up();
  end
endmodule // duog_guard_tb
`default_nettype wire
